// *** src/los_err_map.vh ***
// register map, field positions, reset values and timing counts
`ifndef LOS_ERR_MAP_VH
`define LOS_ERR_MAP_VH
// ----------------------------------------------------------------
// register byte addresses (printed offsets are indices, byte = 4x)
// ----------------------------------------------------------------
`define LOS_CFG_IDX        12'h00d
`define ERR_CTRL_IDX       12'h00e
`define ALARM_CTRL_IDX     12'h00f
`define LOS_CFG_ADDR       14'h0034
`define ERR_CTRL_ADDR      14'h0038
`define ALARM_CTRL_ADDR    14'h003c
`define STATUS_ADDR        14'h0040
`define COUNT_HIGH_ADDR    14'h0044
`define COUNT_LOW_ADDR     14'h0048
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LOS_CFG_RST        8'h15
`define ERR_CTRL_RST       8'h00
`define ALARM_CTRL_RST     8'h00
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LOS_CRIT_BIT       7
`define LOS_THR_HI         6
`define LOS_THR_LO         4
`define TX_AMP_HI          3
`define TX_AMP_LO          2
`define TX_PER_HI          1
`define TX_PER_LO          0
`define EXZ_STD_BIT        7
`define VIOLATION_INSERT_REQUEST_BIT        6
`define PAT_INS_BIT        5
`define CNT_SRC_HI         4
`define CNT_SRC_LO         2
`define CNT_AUTO_BIT       1
`define CNT_TRIG_BIT       0
`define RX_AIS_SYS_BIT     3
`define RX_AIS_LINE_BIT    2
`define TX_AIS_SYS_BIT     1
`define TX_AIS_LINE_BIT    0
`define ALARM_MASK         8'h0f
// ----------------------------------------------------------------
// loss periods in pulses, threshold codes in tenths of a volt
// ----------------------------------------------------------------
`define TX_PER_16          7'd16
`define TX_PER_32          7'd32
`define TX_PER_64          7'd64
`define LINE_N_NORMAL      12'd175
`define LINE_N_ALT         12'd1544
// one second at the line clock rate (pulse enable count)
`define ONE_SECOND_TICKS   32'd2048000
`endif

// *** src/pulse_loss_detect.v ***
// consecutive low-amplitude pulse counter with loss declaration
`timescale 1ns/1ns
module pulse_loss_detect #(
	parameter W = 12
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         ce,
	input  wire         pulse_tick,
	input  wire         below_thr,
	input  wire [W-1:0] limit,
	output reg          loss
);
	reg [W-1:0] run_reg;

	// count ticks while below; declare loss at limit, release above
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= {W{1'b0}};
			loss    <= 1'b0;
		end else if (ce && pulse_tick) begin
			if (!below_thr) begin
				run_reg <= {W{1'b0}};
				loss    <= 1'b0;
			end else if (run_reg >= limit - 1'b1) begin
				loss    <= 1'b1;
			end else begin
				run_reg <= run_reg + 1'b1;
			end
		end
	end
endmodule // pulse_loss_detect

// *** src/pin_sync3.v ***
// three-stage synchroniser, change taken when stages two and three agree
`timescale 1ns/1ns
module pin_sync3 #(
	parameter W = 1
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         ce,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	integer     i;

	// first stage only feeds second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
			s3_reg <= {W{1'b0}};
			q      <= {W{1'b0}};
		end else if (ce) begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_reg[i] == s3_reg[i])
					q[i] <= s3_reg[i];
			end
		end
	end
endmodule // pin_sync3

// *** src/los_error_alarm_control.v ***
// per-channel loss, error count/insert and alarm control with apb slave
//
// Function
// - normal mode: threshold code to 0.5-2.0 V
// - monitor mode: codes 0-3 to 1.0-2.2 V
// - tx loss after 16/32/64 low pulses
// - tx threshold from loss config bits 3:2
// - bit 7 picks ansi or fcc excess-zero
// - bit 6 inserts violation on next mark
// - violation request self-clears after insertion
// - rising bit 5 corrupts one pattern bit
// - pattern insert bit self-clears after insertion
// - count source selects counted error events
// - auto bit: transfer count every second
// - manual: trigger rising edge latches count
// - rx alarm while system loss if enabled
// - rx alarm while line loss if enabled
// - tx alarm while system loss if enabled
// - tx alarm while line loss if enabled
// - error control register, reset zero
// - alarm control register, bits 7:4 reserved
// - line loss after n low pulse intervals
`timescale 1ns/1ns
`include "los_err_map.vh"
module los_error_alarm_control #(
	parameter CW          = 16,
	parameter SECOND_TICKS = `ONE_SECOND_TICKS
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [13:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// line side inputs (asynchronous pins)
	input  wire        line_monitor_mode,
	input  wire        rx_pulse_pin,
	input  wire [4:0]  rx_amplitude_pin,
	input  wire        tx_pulse_pin,
	input  wire [4:0]  tx_amplitude_pin,
	input  wire        system_loss_of_signal,
	// events from the same-clock data paths
	input  wire        line_rate_tick,
	input  wire        line_bipolar_violation,
	input  wire        line_excess_zeros,
	input  wire        system_bipolar_violation,
	input  wire        system_excess_zeros,
	input  wire        pattern_error,
	input  wire        tx_mark,
	input  wire        pattern_bit_tick,
	// outputs to the data paths
	output reg  [4:0]  line_loss_amplitude_threshold,
	output reg  [4:0]  tx_loss_threshold,
	output wire        excess_zero_standard_select,
	output wire        loss_criteria_select,
	output reg         violation_insert_now,
	output reg         pattern_error_now,
	output reg         line_loss_of_signal,
	output reg         tx_loss_of_signal,
	output reg         rx_alarm_indication,
	output reg         tx_alarm_indication,
	output reg  [CW/2-1:0] error_count_high,
	output reg  [CW/2-1:0] error_count_low
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [7:0]    los_cfg_reg;
	reg  [7:0]    err_ctrl_reg;
	reg  [7:0]    alarm_ctrl_reg;
	reg  [CW-1:0] err_cnt_reg;
	reg  [31:0]   sec_cnt_reg;
	reg           trig_prev_reg;
	reg           pat_prev_reg;
	reg           pat_pend_reg;
	reg           rx_pulse_d_reg;
	reg           tx_pulse_d_reg;
	wire          rx_pulse_s;
	wire          tx_pulse_s;
	wire [4:0]    rx_amp_s;
	wire [4:0]    tx_amp_s;
	wire          line_loss_w;
	wire          tx_loss_w;
	wire          wr_en;
	wire          rd_en;
	wire [2:0]    src;
	reg           count_event;
	reg  [6:0]    tx_limit;
	wire          sec_tick;
	wire          manual_latch;
	wire          latch_now;
	wire          bpv_done;
	wire          pat_done;

	// ----------------------------------------------------------------
	// threshold decode functions
	// ----------------------------------------------------------------
	// normal receive: tenths of a volt
	function [4:0] normal_thr;
		input [2:0] code;
		begin
			case (code)
			3'h0:    normal_thr = 5'd5;
			3'h1:    normal_thr = 5'd7;
			3'h2:    normal_thr = 5'd9;
			3'h3:    normal_thr = 5'd12;
			3'h4:    normal_thr = 5'd14;
			3'h5:    normal_thr = 5'd16;
			3'h6:    normal_thr = 5'd18;
			default: normal_thr = 5'd20;
			endcase
		end
	endfunction

	// line monitor: reserved codes give zero (no threshold)
	function [4:0] monitor_thr;
		input [2:0] code;
		begin
			case (code)
			3'h0:    monitor_thr = 5'd10;
			3'h1:    monitor_thr = 5'd14;
			3'h2:    monitor_thr = 5'd18;
			3'h3:    monitor_thr = 5'd22;
			default: monitor_thr = 5'd0;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	pin_sync3 #(.W(12)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d       ({rx_pulse_pin, rx_amplitude_pin,
		           tx_pulse_pin, tx_amplitude_pin}),
		.q       ({rx_pulse_s, rx_amp_s, tx_pulse_s, tx_amp_s})
	);

	// ----------------------------------------------------------------
	// apb slave: zero wait, unmapped reads zero with error
	// ----------------------------------------------------------------
	assign pready  = 1'b1;
	assign wr_en   = psel & penable & pwrite & ce;
	assign rd_en   = psel & ~penable & ~pwrite;
	assign pslverr = psel & penable & ~(
		paddr == `LOS_CFG_ADDR || paddr == `ERR_CTRL_ADDR ||
		paddr == `ALARM_CTRL_ADDR || paddr == `STATUS_ADDR ||
		paddr == `COUNT_HIGH_ADDR || paddr == `COUNT_LOW_ADDR);

	// read data captured in setup phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (ce && rd_en) begin
			case (paddr)
			`LOS_CFG_ADDR:    prdata <= {24'h000000, los_cfg_reg};
			`ERR_CTRL_ADDR:   prdata <= {24'h000000, err_ctrl_reg};
			`ALARM_CTRL_ADDR: prdata <= {24'h000000, alarm_ctrl_reg};
			`STATUS_ADDR:     prdata <= {28'h0000000, rx_alarm_indication,
				tx_alarm_indication, tx_loss_of_signal,
				line_loss_of_signal};
			`COUNT_HIGH_ADDR: prdata <= {{(32-CW/2){1'b0}},
				error_count_high};
			`COUNT_LOW_ADDR:  prdata <= {{(32-CW/2){1'b0}},
				error_count_low};
			default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	assign src      = err_ctrl_reg[`CNT_SRC_HI:`CNT_SRC_LO];
	assign bpv_done = err_ctrl_reg[`VIOLATION_INSERT_REQUEST_BIT] & tx_mark & ce;
	assign pat_done = pat_pend_reg & pattern_bit_tick & ce;

	// writes; hardware clear of insert bits loses to a new write of one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			los_cfg_reg    <= `LOS_CFG_RST;
			err_ctrl_reg   <= `ERR_CTRL_RST;
			alarm_ctrl_reg <= `ALARM_CTRL_RST;
		end else if (ce) begin
			if (bpv_done)
				err_ctrl_reg[`VIOLATION_INSERT_REQUEST_BIT] <= 1'b0;
			if (pat_done)
				err_ctrl_reg[`PAT_INS_BIT] <= 1'b0;
			if (wr_en && paddr == `LOS_CFG_ADDR)
				los_cfg_reg <= pwdata[7:0];
			if (wr_en && paddr == `ERR_CTRL_ADDR)
				err_ctrl_reg <= pwdata[7:0];
			if (wr_en && paddr == `ALARM_CTRL_ADDR)
				alarm_ctrl_reg <= pwdata[7:0] & `ALARM_MASK;
		end
	end

	assign excess_zero_standard_select = err_ctrl_reg[`EXZ_STD_BIT];
	assign loss_criteria_select        = los_cfg_reg[`LOS_CRIT_BIT];

	// ----------------------------------------------------------------
	// thresholds and loss detection
	// ----------------------------------------------------------------
	// selected thresholds, registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_loss_amplitude_threshold <= 5'd0;
			tx_loss_threshold             <= 5'd0;
		end else if (ce) begin
			if (line_monitor_mode)
				line_loss_amplitude_threshold <= monitor_thr(
					los_cfg_reg[`LOS_THR_HI:`LOS_THR_LO]);
			else
				line_loss_amplitude_threshold <= normal_thr(
					los_cfg_reg[`LOS_THR_HI:`LOS_THR_LO]);
			tx_loss_threshold <= normal_thr({1'b0,
				los_cfg_reg[`TX_AMP_HI:`TX_AMP_LO]});
		end
	end

	// tx loss period
	always @* begin
		case (los_cfg_reg[`TX_PER_HI:`TX_PER_LO])
		2'b00:   tx_limit = `TX_PER_16;
		2'b01:   tx_limit = `TX_PER_32;
		default: tx_limit = `TX_PER_64;
		endcase
	end

	// pulse edge detectors on synchronised pins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_pulse_d_reg <= 1'b0;
			tx_pulse_d_reg <= 1'b0;
		end else if (ce) begin
			rx_pulse_d_reg <= rx_pulse_s;
			tx_pulse_d_reg <= tx_pulse_s;
		end
	end

	pulse_loss_detect #(.W(12)) u_line_loss (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.pulse_tick (rx_pulse_s & ~rx_pulse_d_reg),
		.below_thr  (rx_amp_s < line_loss_amplitude_threshold),
		.limit      (loss_criteria_select ? `LINE_N_ALT
		                                  : `LINE_N_NORMAL),
		.loss       (line_loss_w)
	);

	pulse_loss_detect #(.W(12)) u_tx_loss (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.pulse_tick (tx_pulse_s & ~tx_pulse_d_reg),
		.below_thr  (tx_amp_s < tx_loss_threshold),
		.limit      ({5'd0, tx_limit}),
		.loss       (tx_loss_w)
	);

	// ----------------------------------------------------------------
	// insertion strobes
	// ----------------------------------------------------------------
	// violation on next mark, pattern error one bit after rising edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			violation_insert_now <= 1'b0;
			pattern_error_now    <= 1'b0;
			pat_prev_reg         <= 1'b0;
			pat_pend_reg         <= 1'b0;
		end else if (ce) begin
			violation_insert_now <= bpv_done;
			pattern_error_now    <= pat_done;
			pat_prev_reg         <= err_ctrl_reg[`PAT_INS_BIT];
			if (err_ctrl_reg[`PAT_INS_BIT] && !pat_prev_reg)
				pat_pend_reg <= 1'b1;
			else if (pat_done)
				pat_pend_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// error counter and count registers
	// ----------------------------------------------------------------
	// source select; 110 counts nothing
	always @* begin
		case (src)
		3'h1:    count_event = line_bipolar_violation;
		3'h2:    count_event = line_excess_zeros;
		3'h3:    count_event = line_bipolar_violation |
		                       line_excess_zeros;
		3'h4:    count_event = system_bipolar_violation;
		3'h5:    count_event = system_excess_zeros;
		3'h7:    count_event = pattern_error;
		default: count_event = 1'b0;
		endcase
	end

	assign sec_tick = line_rate_tick &&
		(sec_cnt_reg >= SECOND_TICKS - 1);
	assign manual_latch = ~err_ctrl_reg[`CNT_AUTO_BIT] &
		err_ctrl_reg[`CNT_TRIG_BIT] & ~trig_prev_reg;
	assign latch_now = err_ctrl_reg[`CNT_AUTO_BIT] ? sec_tick
		: manual_latch;

	// second timebase, counting, transfer and restart
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_cnt_reg      <= 32'h0000_0000;
			err_cnt_reg      <= {CW{1'b0}};
			trig_prev_reg    <= 1'b0;
			error_count_high <= {(CW/2){1'b0}};
			error_count_low  <= {(CW/2){1'b0}};
		end else if (ce) begin
			trig_prev_reg <= err_ctrl_reg[`CNT_TRIG_BIT];
			if (line_rate_tick)
				sec_cnt_reg <= sec_tick ? 32'h0000_0000
					: sec_cnt_reg + 32'h0000_0001;
			if (latch_now) begin
				error_count_high <= err_cnt_reg[CW-1:CW/2];
				error_count_low  <= err_cnt_reg[CW/2-1:0];
				err_cnt_reg <= {{(CW-1){1'b0}}, count_event};
			end else if (count_event && ~&err_cnt_reg)
				err_cnt_reg <= err_cnt_reg + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// loss flags and alarm generation
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_loss_of_signal <= 1'b0;
			tx_loss_of_signal   <= 1'b0;
			rx_alarm_indication <= 1'b0;
			tx_alarm_indication <= 1'b0;
		end else if (ce) begin
			line_loss_of_signal <= line_loss_w;
			tx_loss_of_signal   <= tx_loss_w;
			rx_alarm_indication <=
				(alarm_ctrl_reg[`RX_AIS_SYS_BIT] &
				 system_loss_of_signal) |
				(alarm_ctrl_reg[`RX_AIS_LINE_BIT] & line_loss_w);
			tx_alarm_indication <=
				(alarm_ctrl_reg[`TX_AIS_SYS_BIT] &
				 system_loss_of_signal) |
				(alarm_ctrl_reg[`TX_AIS_LINE_BIT] & line_loss_w);
		end
	end
endmodule // los_error_alarm_control

// *** tb/los_error_alarm_control_chk.sv ***
// assertion checker for the loss, error and alarm control block
`timescale 1ns/1ns
`include "los_err_map.vh"
module los_error_alarm_control_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        ce,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [13:0] paddr,
	input wire [31:0] pwdata,
	input wire        line_monitor_mode,
	input wire        system_loss_of_signal,
	input wire        tx_mark,
	input wire        pattern_bit_tick,
	input wire [4:0]  line_loss_amplitude_threshold,
	input wire [4:0]  tx_loss_threshold,
	input wire        excess_zero_standard_select,
	input wire        loss_criteria_select,
	input wire        violation_insert_now,
	input wire        pattern_error_now,
	input wire        rx_alarm_indication,
	input wire        tx_alarm_indication
);
	localparam logic [39:0] NTAB = {5'h14, 5'h12, 5'h10, 5'h0e,
		5'h0c, 5'h09, 5'h07, 5'h05};
	logic [3:0] alarm_m;
	logic [7:0] cfg_m;
	wire        wr_ok = psel && penable && pwrite && ce;
	wire [4:0]  thr_exp = !line_monitor_mode ? NTAB[cfg_m[6:4] * 5 +: 5] :
		(cfg_m[6] ? 5'h00 : 5'h0a + {1'b0, cfg_m[5:4], 2'b00});
	wire [4:0]  tx_exp = NTAB[{1'b0, cfg_m[3:2]} * 5 +: 5];

	// mirror of alarm and loss config registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_m <= 4'h0;
			cfg_m   <= `LOS_CFG_RST;
		end else if (wr_ok && paddr == `ALARM_CTRL_ADDR) begin
			alarm_m <= pwdata[3:0];
		end else if (wr_ok && paddr == `LOS_CFG_ADDR) begin
			cfg_m <= pwdata[7:0];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_rx_sys;
		!$past(alarm_m[2]) |->
			rx_alarm_indication == $past(alarm_m[3] && system_loss_of_signal);
	endproperty
	a_rx_sys: assert property (p_rx_sys) else $error("rx alarm wrong");
	property p_tx_sys;
		!$past(alarm_m[0]) |->
			tx_alarm_indication == $past(alarm_m[1] && system_loss_of_signal);
	endproperty
	a_tx_sys: assert property (p_tx_sys) else $error("tx alarm wrong");
	property p_vio;
		violation_insert_now |-> $past(tx_mark);
	endproperty
	a_vio: assert property (p_vio) else $error("violation without mark");
	property p_pat;
		pattern_error_now |-> $past(pattern_bit_tick);
	endproperty
	a_pat: assert property (p_pat) else $error("pattern error untimed");
	property p_exz;
		wr_ok && paddr == `ERR_CTRL_ADDR |=>
			excess_zero_standard_select == $past(pwdata[7]);
	endproperty
	a_exz: assert property (p_exz) else $error("excess zero select");
	property p_crit;
		wr_ok && paddr == `LOS_CFG_ADDR |=>
			loss_criteria_select == $past(pwdata[7]);
	endproperty
	a_crit: assert property (p_crit) else $error("criteria select");
	property p_thr;
		wr_ok && paddr == `LOS_CFG_ADDR |->
			##[1:3] line_loss_amplitude_threshold == thr_exp;
	endproperty
	a_thr: assert property (p_thr) else $error("line threshold");
	property p_txthr;
		wr_ok && paddr == `LOS_CFG_ADDR |-> ##[1:3] tx_loss_threshold == tx_exp;
	endproperty
	a_txthr: assert property (p_txthr) else $error("tx threshold");
endmodule // los_error_alarm_control_chk

bind los_error_alarm_control los_error_alarm_control_chk u_chk (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.line_monitor_mode(line_monitor_mode),
	.system_loss_of_signal(system_loss_of_signal), .tx_mark(tx_mark),
	.pattern_bit_tick(pattern_bit_tick),
	.line_loss_amplitude_threshold(line_loss_amplitude_threshold),
	.tx_loss_threshold(tx_loss_threshold),
	.excess_zero_standard_select(excess_zero_standard_select),
	.loss_criteria_select(loss_criteria_select),
	.violation_insert_now(violation_insert_now),
	.pattern_error_now(pattern_error_now),
	.rx_alarm_indication(rx_alarm_indication),
	.tx_alarm_indication(tx_alarm_indication));

// *** tb/los_error_alarm_control_tb.sv ***
// self-checking bench for the loss, error and alarm control block
`timescale 1ns/1ns
`include "los_err_map.vh"
module los_error_alarm_control_tb;
	logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_seen;
	logic [13:0] paddr = 14'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, mon = 1'b0, sys_loss = 1'b0;
	logic        rx_pin = 1'b0, tx_pin = 1'b0, tick = 1'b0;
	logic        tx_mark = 1'b0, pat_tick = 1'b0;
	logic [4:0]  amp_v = 5'h1f, evt = 5'h00, thr, tx_thr;
	logic        exz, crit, vio_now, pat_now, line_los, tx_los, rx_ais, tx_ais;
	logic [7:0]  cnt_hi, cnt_lo;
	logic [4:0]  ntab [8] = '{5'h05, 5'h07, 5'h09, 5'h0c, 5'h0e, 5'h10,
		5'h12, 5'h14};
	logic [4:0]  mtab [8] = '{5'h0a, 5'h0e, 5'h12, 5'h16, 5'h00, 5'h00,
		5'h00, 5'h00};
	logic [7:0]  ctab [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08,
		8'h00, 8'h10};
	int          bad_count = 0, checks_done = 0;

	always #4 pclk = ~pclk;

	los_error_alarm_control #(.SECOND_TICKS(8)) dut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.line_monitor_mode(mon), .rx_pulse_pin(rx_pin),
		.rx_amplitude_pin(amp_v), .tx_pulse_pin(tx_pin),
		.tx_amplitude_pin(amp_v), .system_loss_of_signal(sys_loss),
		.line_rate_tick(tick), .line_bipolar_violation(evt[0]),
		.line_excess_zeros(evt[1]), .system_bipolar_violation(evt[2]),
		.system_excess_zeros(evt[3]), .pattern_error(evt[4]),
		.tx_mark(tx_mark), .pattern_bit_tick(pat_tick),
		.line_loss_amplitude_threshold(thr), .tx_loss_threshold(tx_thr),
		.excess_zero_standard_select(exz), .loss_criteria_select(crit),
		.violation_insert_now(vio_now), .pattern_error_now(pat_now),
		.line_loss_of_signal(line_los), .tx_loss_of_signal(tx_los),
		.rx_alarm_indication(rx_ais), .tx_alarm_indication(tx_ais),
		.error_count_high(cnt_hi), .error_count_low(cnt_lo));

	// ---------------------------------------------------------------
	// compare, verdict and bus tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("mismatches %0d of %0d checks", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [13:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			print_verdict();
		end
		q = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [13:0] a, input logic [7:0] e);
		logic [31:0] q;
		apb(1'b0, a, 8'h00, q);
		check(q, {24'h0, e});
	endtask

	// line-side pulses, slow enough for the pin synchronisers
	task automatic pulses(input logic tx, input int n);
		repeat (n) begin
			@(posedge pclk);
			if (tx)
				tx_pin <= 1'b1;
			else
				rx_pin <= 1'b1;
			repeat (5) @(posedge pclk);
			tx_pin <= 1'b0;
			rx_pin <= 1'b0;
			repeat (5) @(posedge pclk);
		end
	endtask

	task automatic amp(input logic [4:0] v);
		@(posedge pclk);
		amp_v <= v;
		repeat (6) @(posedge pclk);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge pclk);
			tick <= 1'b1;
			@(posedge pclk);
			tick <= 1'b0;
		end
		repeat (3) @(posedge pclk);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(`LOS_CFG_ADDR, 8'h15);
		rd(`ERR_CTRL_ADDR, 8'h00);
		rd(`ALARM_CTRL_ADDR, 8'h00);
		wr(`ALARM_CTRL_ADDR, 8'hff);
		rd(`ALARM_CTRL_ADDR, 8'h0f);
		rd(14'h0100, 8'h00);
		check(err_seen, 1'b1);
		// threshold tables in both modes
		for (int m = 0; m < 2; m++) begin
			mon <= m[0];
			for (int c = 0; c < 8; c++) begin
				wr(`LOS_CFG_ADDR, {c[0], c[2:0], c[1:0], 2'b01});
				repeat (3) @(posedge pclk);
				check(thr, m ? mtab[c] : ntab[c]);
				check(tx_thr, ntab[c[1:0]]);
				check(crit, c[0]);
			end
		end
		mon <= 1'b0;
		wr(`LOS_CFG_ADDR, 8'h15);
		for (int b = 1; b >= 0; b--) begin
			wr(`ERR_CTRL_ADDR, {b[0], 7'h00});
			repeat (2) @(posedge pclk);
			check(exz, b[0]);
		end
		// violation and pattern error insertion
		wr(`ERR_CTRL_ADDR, 8'h40);
		rd(`ERR_CTRL_ADDR, 8'h40);
		@(posedge pclk);
		tx_mark <= 1'b1;
		@(posedge pclk);
		tx_mark <= 1'b0;
		#1;
		check(vio_now, 1'b1);
		rd(`ERR_CTRL_ADDR, 8'h00);
		wr(`ERR_CTRL_ADDR, 8'h20);
		repeat (3) @(posedge pclk);
		pat_tick <= 1'b1;
		@(posedge pclk);
		pat_tick <= 1'b0;
		#1;
		check(pat_now, 1'b1);
		rd(`ERR_CTRL_ADDR, 8'h00);
		// each event input gets a distinct number of events
		for (int c = 0; c < 8; c++) begin
			wr(`ERR_CTRL_ADDR, {3'h0, c[2:0], 2'b00});
			wr(`ERR_CTRL_ADDR, {3'h0, c[2:0], 2'b01});
			wr(`ERR_CTRL_ADDR, {3'h0, c[2:0], 2'b00});
			for (int i = 0; i < 5; i++)
				repeat (1 << i) begin
					@(posedge pclk);
					evt <= 5'h01 << i;
				end
			@(posedge pclk);
			evt <= 5'h00;
			wr(`ERR_CTRL_ADDR, {3'h0, c[2:0], 2'b01});
			repeat (3) @(posedge pclk);
			rd(`COUNT_LOW_ADDR, ctab[c]);
			check({cnt_hi, cnt_lo}, ctab[c]);
		end
		// automatic transfer every eight ticks
		wr(`ERR_CTRL_ADDR, 8'h06);
		ticks(16);
		repeat (3) begin
			@(posedge pclk);
			evt <= 5'h01;
			@(posedge pclk);
			evt <= 5'h00;
		end
		wr(`ERR_CTRL_ADDR, 8'h07);
		repeat (3) @(posedge pclk);
		check(cnt_lo, 8'h00);
		ticks(7);
		check(cnt_lo, 8'h00);
		ticks(1);
		check(cnt_lo, 8'h03);
		rd(`COUNT_HIGH_ADDR, 8'h00);
		// alarms from system loss, then from line loss
		wr(`ALARM_CTRL_ADDR, 8'h0a);
		sys_loss <= 1'b1;
		repeat (3) @(posedge pclk);
		check(rx_ais, 1'b1);
		check(tx_ais, 1'b1);
		wr(`ALARM_CTRL_ADDR, 8'h05);
		repeat (3) @(posedge pclk);
		check(rx_ais, 1'b0);
		check(tx_ais, 1'b0);
		sys_loss <= 1'b0;
		amp(5'h00);
		pulses(1'b0, 174);
		check(line_los, 1'b0);
		pulses(1'b0, 1);
		check(line_los, 1'b1);
		check(rx_ais, 1'b1);
		check(tx_ais, 1'b1);
		rd(`STATUS_ADDR, 8'h0d);
		wr(`ALARM_CTRL_ADDR, 8'h00);
		repeat (3) @(posedge pclk);
		check(rx_ais, 1'b0);
		check(tx_ais, 1'b0);
		// writes are lost while the clock enable is low
		ce <= 1'b0;
		wr(`ALARM_CTRL_ADDR, 8'h0f);
		ce <= 1'b1;
		rd(`ALARM_CTRL_ADDR, 8'h00);
		// transmit loss after 16, 32 and 64 low pulses
		for (int p = 0; p < 3; p++) begin
			wr(`LOS_CFG_ADDR, 8'h14 | p[7:0]);
			pulses(1'b1, (16 << p) - 1);
			check(tx_los, 1'b0);
			pulses(1'b1, 1);
			check(tx_los, 1'b1);
			amp(5'h1f);
			pulses(1'b1, 1);
			check(tx_los, 1'b0);
			amp(5'h00);
		end
		// line loss with the alternate criteria count
		wr(`LOS_CFG_ADDR, 8'h95);
		amp(5'h1f);
		pulses(1'b0, 1);
		check(line_los, 1'b0);
		amp(5'h00);
		pulses(1'b0, 1543);
		check(line_los, 1'b0);
		pulses(1'b0, 1);
		check(line_los, 1'b1);
		print_verdict();
	end
endmodule // los_error_alarm_control_tb
